// ### design/tci_host.sv
// host master end driving the touch-controller i2c port
`timescale 1ns/1ps
`include "tci_cfg.svh"
module tci_host (
  input wire logic clk,
  input wire logic rst_n,
  tci_if.host bus,
  input wire logic addr_sel,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_read,
  input wire logic [15:0] cmd_ptr,
  input wire logic [7:0] cmd_len,
  input wire logic [7:0] wdata,
  output logic wdata_take,
  output logic [7:0] rdata,
  output logic rdata_valid,
  output logic done,
  output logic nack_err
);

  // ----------------------------------------------------------------------
  // sda synchroniser
  // ----------------------------------------------------------------------
  logic sda_m_reg, sda_s_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_m_reg <= 1'b1;
      sda_s_reg <= 1'b1;
    end else begin
      sda_m_reg <= bus.sda;
      sda_s_reg <= sda_m_reg;
    end
  end

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  tci_pkg::tci_host_state_t st_reg, st_next;
  logic [1:0] sub_reg, sub_next;
  logic [9:0] cnt_reg, cnt_next;
  logic half_reg, half_next;
  logic [3:0] bit_reg, bit_next;
  logic [8:0] bidx_reg, bidx_next;
  logic [7:0] sh_reg, sh_next;
  logic rd_reg, rd_next;
  logic [15:0] ptr_reg, ptr_next;
  logic [7:0] len_reg, len_next;
  logic scl_rel_reg, scl_rel_next;
  logic sda_rel_reg, sda_rel_next;
  logic drv_reg, drv_next;
  logic rp_reg, rp_next;
  logic sel_reg, sel_next;
  logic [7:0] rdata_reg, rdata_next;
  logic rdv_reg, rdv_next;
  logic done_reg, done_next;
  logic err_reg, err_next;
  logic take_reg, take_next;
  logic tick, is_rx, last_rx, last_wr;
  logic [8:0] bidx_inc;
  logic [7:0] nb;

  assign tick = (cnt_reg == 10'h000);
  assign is_rx = rd_reg && (bidx_reg > `TCI_IDX_DATA0);
  assign last_rx = (bidx_reg == ({1'b0, len_reg} + `TCI_IDX_DATA0));
  assign last_wr = (bidx_reg == ({1'b0, len_reg} + `TCI_IDX_PTR_LO));
  assign bidx_inc = bidx_reg + 9'h001;
  // pointer goes most significant byte first
  assign nb = (bidx_inc == `TCI_IDX_PTR_HI) ? ptr_reg[15:8] :
              (bidx_inc == `TCI_IDX_PTR_LO) ? ptr_reg[7:0] :
              rd_reg ? 8'hff : wdata;

  always_comb begin
    st_next = st_reg;
    sub_next = sub_reg;
    cnt_next = tick ? cnt_reg : cnt_reg - 10'h001;
    half_next = half_reg;
    bit_next = bit_reg;
    bidx_next = bidx_reg;
    sh_next = sh_reg;
    rd_next = rd_reg;
    ptr_next = ptr_reg;
    len_next = len_reg;
    scl_rel_next = scl_rel_reg;
    sda_rel_next = sda_rel_reg;
    drv_next = drv_reg;
    rp_next = rp_reg;
    sel_next = sel_reg;
    rdata_next = rdata_reg;
    rdv_next = 1'b0;
    done_next = 1'b0;
    err_next = err_reg;
    take_next = 1'b0;
    case (st_reg)
      tci_pkg::HST_PON: begin
        sel_next = addr_sel;
        if (tick) begin
          if (!rp_reg) begin
            rp_next = 1'b1;
            cnt_next = 10'(`TCI_RST_CYC);
          end else begin
            st_next = tci_pkg::HST_IDLE;
          end
        end
      end
      tci_pkg::HST_IDLE: begin
        if (cmd_valid) begin
          st_next = tci_pkg::HST_START;
          sub_next = 2'h0;
          cnt_next = 10'(`TCI_LO_CYC);
          scl_rel_next = 1'b0;
          drv_next = 1'b1;
          rd_next = cmd_read;
          ptr_next = cmd_ptr;
          len_next = cmd_len;
          bidx_next = 9'h000;
          err_next = 1'b0;
          sh_next = {sel_reg ? `TCI_ADDR7_ALT : `TCI_ADDR7_MAIN, 1'b0};
        end
      end
      tci_pkg::HST_START: begin
        if (tick) begin
          case (sub_reg)
            2'h0: begin
              scl_rel_next = 1'b1;
              cnt_next = 10'(`TCI_SU_CYC);
              sub_next = 2'h1;
            end
            2'h1: begin
              sda_rel_next = 1'b0;
              cnt_next = 10'(`TCI_HI_CYC);
              sub_next = 2'h2;
            end
            default: begin
              scl_rel_next = 1'b0;
              st_next = tci_pkg::HST_BIT;
              half_next = 1'b0;
              bit_next = 4'h0;
              cnt_next = 10'(`TCI_LO_CYC);
              drv_next = sh_reg[7];
            end
          endcase
        end
      end
      tci_pkg::HST_BIT: begin
        if (tick && !half_reg) begin
          scl_rel_next = 1'b1;
          half_next = 1'b1;
          cnt_next = 10'(`TCI_HI_CYC);
        end else if (tick) begin
          scl_rel_next = 1'b0;
          half_next = 1'b0;
          cnt_next = 10'(`TCI_LO_CYC);
          if (bit_reg != `TCI_ACK_BIT) begin
            sh_next = {sh_reg[6:0], is_rx ? sda_s_reg : 1'b1};
            bit_next = bit_reg + 4'h1;
            if (bit_reg == `TCI_LAST_BIT) begin
              drv_next = is_rx ? last_rx : 1'b1;
            end else begin
              drv_next = is_rx ? 1'b1 : sh_reg[6];
            end
          end else begin
            bit_next = 4'h0;
            if (is_rx) begin
              rdata_next = sh_reg;
              rdv_next = 1'b1;
            end
            if (!is_rx && sda_s_reg) begin
              err_next = 1'b1;
              st_next = tci_pkg::HST_STOP;
              sub_next = 2'h0;
              drv_next = 1'b0;
            end else if (is_rx ? last_rx : (!rd_reg && last_wr)) begin
              st_next = tci_pkg::HST_STOP;
              sub_next = 2'h0;
              drv_next = 1'b0;
            end else if (rd_reg && bidx_reg == `TCI_IDX_PTR_LO) begin
              st_next = tci_pkg::HST_START;
              sub_next = 2'h0;
              drv_next = 1'b1;
              bidx_next = `TCI_IDX_DATA0;
              sh_next = {sel_reg ? `TCI_ADDR7_ALT : `TCI_ADDR7_MAIN, 1'b1};
            end else begin
              bidx_next = bidx_inc;
              sh_next = nb;
              drv_next = (rd_reg && bidx_inc > `TCI_IDX_DATA0) ? 1'b1 : nb[7];
              take_next = !rd_reg && bidx_inc >= `TCI_IDX_DATA0;
            end
          end
        end
      end
      tci_pkg::HST_STOP: begin
        if (tick) begin
          case (sub_reg)
            2'h0: begin
              scl_rel_next = 1'b1;
              cnt_next = 10'(`TCI_SU_CYC);
              sub_next = 2'h1;
            end
            2'h1: begin
              sda_rel_next = 1'b1;
              cnt_next = 10'(`TCI_LO_CYC);
              sub_next = 2'h2;
            end
            default: begin
              st_next = tci_pkg::HST_IDLE;
              done_next = 1'b1;
            end
          endcase
        end
      end
      default: begin
        st_next = tci_pkg::HST_IDLE;
      end
    endcase
    // sda moves mid-low, well clear of either scl edge
    if (cnt_reg == 10'(`TCI_MID_CYC) && !scl_rel_reg) begin
      sda_rel_next = drv_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= tci_pkg::HST_PON;
      sub_reg <= 2'h0;
      cnt_reg <= 10'(`TCI_RST_CYC);
      half_reg <= 1'b0;
      bit_reg <= 4'h0;
      bidx_reg <= 9'h000;
      sh_reg <= 8'hff;
      rd_reg <= 1'b0;
      ptr_reg <= 16'h0000;
      len_reg <= 8'h00;
      scl_rel_reg <= 1'b1;
      sda_rel_reg <= 1'b1;
      drv_reg <= 1'b1;
      rp_reg <= 1'b0;
      sel_reg <= 1'b0;
      rdata_reg <= 8'h00;
      rdv_reg <= 1'b0;
      done_reg <= 1'b0;
      err_reg <= 1'b0;
      take_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      sub_reg <= sub_next;
      cnt_reg <= cnt_next;
      half_reg <= half_next;
      bit_reg <= bit_next;
      bidx_reg <= bidx_next;
      sh_reg <= sh_next;
      rd_reg <= rd_next;
      ptr_reg <= ptr_next;
      len_reg <= len_next;
      scl_rel_reg <= scl_rel_next;
      sda_rel_reg <= sda_rel_next;
      drv_reg <= drv_next;
      rp_reg <= rp_next;
      sel_reg <= sel_next;
      rdata_reg <= rdata_next;
      rdv_reg <= rdv_next;
      done_reg <= done_next;
      err_reg <= err_next;
      take_reg <= take_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign bus.scl_oe_n_host = scl_rel_reg;
  assign bus.scl_o_host = 1'b0;
  assign bus.sda_oe_n_host = sda_rel_reg;
  assign bus.sda_o_host = 1'b0;
  assign bus.rst_pin_n = rp_reg;
  assign bus.int_pin = sel_reg;
  assign cmd_ready = (st_reg == tci_pkg::HST_IDLE);
  assign wdata_take = take_reg;
  assign rdata = rdata_reg;
  assign rdata_valid = rdv_reg;
  assign done = done_reg;
  assign nack_err = err_reg;

endmodule // tci_host

// ### design/tci_cfg.svh
// timing, address and field constants for the touch-controller i2c port
`ifndef TCI_CFG_SVH
`define TCI_CFG_SVH

// ----------------------------------------------------------------------
// clock and bus timing
// ----------------------------------------------------------------------
`define TCI_CLK_NS 10
`define TCI_TBIT_NS 2500
`define TCI_THI_NS 600
`define TCI_TSU_NS 600
`define TCI_TRST_NS 10000
`define TCI_CYC_UP(ns) (((ns) + `TCI_CLK_NS - 1) / `TCI_CLK_NS)
`define TCI_HI_CYC (`TCI_CYC_UP(`TCI_THI_NS))
`define TCI_LO_CYC (`TCI_CYC_UP(`TCI_TBIT_NS) - `TCI_HI_CYC)
`define TCI_MID_CYC (`TCI_LO_CYC / 2)
`define TCI_SU_CYC (`TCI_CYC_UP(`TCI_TSU_NS))
`define TCI_RST_CYC (`TCI_CYC_UP(`TCI_TRST_NS))

// ----------------------------------------------------------------------
// target addresses (7-bit forms of the two selectable pairs)
// ----------------------------------------------------------------------
`define TCI_ADDR7_MAIN 7'h5d
`define TCI_ADDR7_ALT 7'h14

// ----------------------------------------------------------------------
// byte framing
// ----------------------------------------------------------------------
`define TCI_LAST_BIT 4'h7
`define TCI_ACK_BIT 4'h8
`define TCI_IDX_PTR_HI 9'h001
`define TCI_IDX_PTR_LO 9'h002
`define TCI_IDX_DATA0 9'h003
`define TCI_PTR_STEP 16'h0001

`endif

// ### design/tci_pkg.sv
// state and phase types for the touch-controller i2c port
package tci_pkg;

  typedef enum logic [4:0] {
    TGT_IDLE = 5'h01,
    TGT_RX = 5'h02,
    TGT_ACK = 5'h04,
    TGT_TX = 5'h08,
    TGT_TXACK = 5'h10
  } tci_tgt_state_t;

  typedef enum logic [3:0] {
    PH_ADDR = 4'h1,
    PH_PTR_HI = 4'h2,
    PH_PTR_LO = 4'h4,
    PH_DATA = 4'h8
  } tci_phase_t;

  typedef enum logic [4:0] {
    HST_PON = 5'h01,
    HST_IDLE = 5'h02,
    HST_START = 5'h04,
    HST_BIT = 5'h08,
    HST_STOP = 5'h10
  } tci_host_state_t;

endpackage

// ### design/tci_if.sv
// two-wire bus plus strap pins joining host and touch target
`timescale 1ns/1ps
interface tci_if;
  logic scl_oe_n_host;
  logic scl_o_host;
  logic sda_oe_n_host;
  logic sda_o_host;
  logic sda_oe_n_tgt;
  logic sda_o_tgt;
  logic rst_pin_n;
  logic int_pin;
  logic scl;
  logic sda;

  // ----------------------------------------------------------------------
  // wired-and with pull-up: a released line reads high
  // ----------------------------------------------------------------------
  assign scl = scl_oe_n_host ? 1'b1 : scl_o_host;
  assign sda = (sda_oe_n_host ? 1'b1 : sda_o_host) &
               (sda_oe_n_tgt ? 1'b1 : sda_o_tgt);

  modport host (
    output scl_oe_n_host,
    output scl_o_host,
    output sda_oe_n_host,
    output sda_o_host,
    output rst_pin_n,
    output int_pin,
    input scl,
    input sda
  );

  modport tgt (
    output sda_oe_n_tgt,
    output sda_o_tgt,
    input rst_pin_n,
    input int_pin,
    input scl,
    input sda
  );
endinterface

// ### design/tci_target.sv
// touch-controller i2c target end with 16-bit register pointer
`timescale 1ns/1ps
`include "tci_cfg.svh"
module tci_target (
  input wire logic clk,
  input wire logic rst_n,
  tci_if.tgt bus,
  output logic wr_en,
  output logic [15:0] wr_addr,
  output logic [7:0] wr_data,
  output logic rd_en,
  output logic [15:0] rd_addr,
  input wire logic [7:0] rd_data,
  output logic addr_sel,
  output logic busy
);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic scl_m_reg, scl_s_reg, scl_d_reg;
  logic sda_m_reg, sda_s_reg, sda_d_reg;
  logic rp_m_reg, rp_s_reg, rp_d_reg;
  logic int_m_reg, int_s_reg;
  logic scl_rise, scl_fall, start_det, stop_det, rp_rise;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_m_reg <= 1'b1;
      scl_s_reg <= 1'b1;
      scl_d_reg <= 1'b1;
      sda_m_reg <= 1'b1;
      sda_s_reg <= 1'b1;
      sda_d_reg <= 1'b1;
      rp_m_reg <= 1'b0;
      rp_s_reg <= 1'b0;
      rp_d_reg <= 1'b0;
      int_m_reg <= 1'b0;
      int_s_reg <= 1'b0;
    end else begin
      scl_m_reg <= bus.scl;
      scl_s_reg <= scl_m_reg;
      scl_d_reg <= scl_s_reg;
      sda_m_reg <= bus.sda;
      sda_s_reg <= sda_m_reg;
      sda_d_reg <= sda_s_reg;
      rp_m_reg <= bus.rst_pin_n;
      rp_s_reg <= rp_m_reg;
      rp_d_reg <= rp_s_reg;
      int_m_reg <= bus.int_pin;
      int_s_reg <= int_m_reg;
    end
  end

  assign scl_rise = scl_s_reg & ~scl_d_reg;
  assign scl_fall = ~scl_s_reg & scl_d_reg;
  // both scl samples high, so an sda change at an scl edge is no condition
  assign start_det = scl_s_reg & scl_d_reg & sda_d_reg & ~sda_s_reg;
  assign stop_det = scl_s_reg & scl_d_reg & ~sda_d_reg & sda_s_reg;
  assign rp_rise = rp_s_reg & ~rp_d_reg;

  // ----------------------------------------------------------------------
  // address match
  // ----------------------------------------------------------------------
  function automatic logic addr_hit(input logic [7:0] b, input logic sel);
    addr_hit = sel ? (b[7:1] == `TCI_ADDR7_ALT) : (b[7:1] == `TCI_ADDR7_MAIN);
  endfunction

  // ----------------------------------------------------------------------
  // protocol engine
  // ----------------------------------------------------------------------
  tci_pkg::tci_tgt_state_t st_reg, st_next;
  tci_pkg::tci_phase_t ph_reg, ph_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] sh_reg, sh_next;
  logic rw_reg, rw_next;
  logic [15:0] ptr_reg, ptr_next;
  logic oe_reg, oe_next;
  logic ack_reg, ack_next;
  logic sel_reg, sel_next;
  logic ld_reg, ld_next;
  logic wr_en_reg, wr_en_next;
  logic [15:0] wr_addr_reg, wr_addr_next;
  logic [7:0] wr_data_reg, wr_data_next;
  logic rd_en_reg, rd_en_next;

  always_comb begin
    st_next = st_reg;
    ph_next = ph_reg;
    bit_next = bit_reg;
    sh_next = sh_reg;
    rw_next = rw_reg;
    ptr_next = ptr_reg;
    oe_next = oe_reg;
    ack_next = ack_reg;
    sel_next = sel_reg;
    ld_next = rd_en_reg;
    wr_en_next = 1'b0;
    wr_addr_next = wr_addr_reg;
    wr_data_next = wr_data_reg;
    rd_en_next = 1'b0;
    // strap level caught as the reset pin rises, not at our own reset
    if (rp_rise) begin
      sel_next = int_s_reg;
    end
    // read data arrives one cycle after the request, while scl is low
    if (ld_reg) begin
      sh_next = rd_data;
      oe_next = rd_data[7];
    end
    if (!rp_s_reg) begin
      st_next = tci_pkg::TGT_IDLE;
      oe_next = 1'b1;
    end else if (start_det) begin
      st_next = tci_pkg::TGT_RX;
      ph_next = tci_pkg::PH_ADDR;
      bit_next = 4'h0;
      oe_next = 1'b1;
    end else if (stop_det) begin
      st_next = tci_pkg::TGT_IDLE;
      oe_next = 1'b1;
    end else begin
      case (st_reg)
        tci_pkg::TGT_IDLE: begin
          oe_next = 1'b1;
        end
        tci_pkg::TGT_RX: begin
          if (scl_rise && bit_reg != `TCI_ACK_BIT) begin
            sh_next = {sh_reg[6:0], sda_s_reg};
            bit_next = bit_reg + 4'h1;
          end
          if (scl_fall && bit_reg == `TCI_ACK_BIT) begin
            bit_next = 4'h0;
            st_next = tci_pkg::TGT_ACK;
            oe_next = 1'b0;
            case (ph_reg)
              tci_pkg::PH_ADDR: begin
                if (addr_hit(sh_reg, sel_reg)) begin
                  rw_next = sh_reg[0];
                end else begin
                  st_next = tci_pkg::TGT_IDLE;
                  oe_next = 1'b1;
                end
              end
              tci_pkg::PH_PTR_HI: begin
                ptr_next[15:8] = sh_reg;
                ph_next = tci_pkg::PH_PTR_LO;
              end
              tci_pkg::PH_PTR_LO: begin
                ptr_next[7:0] = sh_reg;
                ph_next = tci_pkg::PH_DATA;
              end
              default: begin
                wr_en_next = 1'b1;
                wr_addr_next = ptr_reg;
                wr_data_next = sh_reg;
                ptr_next = ptr_reg + `TCI_PTR_STEP;
              end
            endcase
          end
        end
        tci_pkg::TGT_ACK: begin
          if (scl_fall) begin
            oe_next = 1'b1;
            bit_next = 4'h0;
            if (ph_reg == tci_pkg::PH_ADDR && rw_reg) begin
              st_next = tci_pkg::TGT_TX;
              rd_en_next = 1'b1;
            end else begin
              st_next = tci_pkg::TGT_RX;
              if (ph_reg == tci_pkg::PH_ADDR) begin
                ph_next = tci_pkg::PH_PTR_HI;
              end
            end
          end
        end
        tci_pkg::TGT_TX: begin
          // sda only moves after a seen scl fall, so it never moves high
          if (scl_fall) begin
            if (bit_reg == `TCI_LAST_BIT) begin
              st_next = tci_pkg::TGT_TXACK;
              oe_next = 1'b1;
              ptr_next = ptr_reg + `TCI_PTR_STEP;
            end else begin
              sh_next = {sh_reg[6:0], 1'b1};
              oe_next = sh_reg[6];
              bit_next = bit_reg + 4'h1;
            end
          end
        end
        tci_pkg::TGT_TXACK: begin
          if (scl_rise) begin
            ack_next = ~sda_s_reg;
          end
          if (scl_fall) begin
            bit_next = 4'h0;
            if (ack_reg) begin
              st_next = tci_pkg::TGT_TX;
              rd_en_next = 1'b1;
            end else begin
              st_next = tci_pkg::TGT_IDLE;
              oe_next = 1'b1;
            end
          end
        end
        default: begin
          st_next = tci_pkg::TGT_IDLE;
          oe_next = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= tci_pkg::TGT_IDLE;
      ph_reg <= tci_pkg::PH_ADDR;
      bit_reg <= 4'h0;
      sh_reg <= 8'hff;
      rw_reg <= 1'b0;
      ptr_reg <= 16'h0000;
      oe_reg <= 1'b1;
      ack_reg <= 1'b0;
      sel_reg <= 1'b0;
      ld_reg <= 1'b0;
      wr_en_reg <= 1'b0;
      wr_addr_reg <= 16'h0000;
      wr_data_reg <= 8'h00;
      rd_en_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      ph_reg <= ph_next;
      bit_reg <= bit_next;
      sh_reg <= sh_next;
      rw_reg <= rw_next;
      ptr_reg <= ptr_next;
      oe_reg <= oe_next;
      ack_reg <= ack_next;
      sel_reg <= sel_next;
      ld_reg <= ld_next;
      wr_en_reg <= wr_en_next;
      wr_addr_reg <= wr_addr_next;
      wr_data_reg <= wr_data_next;
      rd_en_reg <= rd_en_next;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign bus.sda_oe_n_tgt = oe_reg;
  assign bus.sda_o_tgt = 1'b0;
  assign wr_en = wr_en_reg;
  assign wr_addr = wr_addr_reg;
  assign wr_data = wr_data_reg;
  assign rd_en = rd_en_reg;
  assign rd_addr = ptr_reg;
  assign addr_sel = sel_reg;
  assign busy = ~st_reg[0];

endmodule // tci_target

// ### tb/tci_monitor.sv
// bus checker for the touch-controller i2c link
`timescale 1ns/1ps
`include "tci_cfg.svh"
module tci_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_oe_n_tgt,
  input wire logic rst_pin_n,
  input wire logic int_pin
);
  // ------------------------------------
  // byte tracking
  // ------------------------------------
  logic scl_reg, sda_reg, first_reg, rd_reg, hit_reg, idle_reg, sel_reg;
  logic [3:0] cnt_reg;
  logic [7:0] sh_reg;
  logic [8:0] per_reg;
  wire st = scl & scl_reg & sda_reg & !sda;
  wire sp = scl & scl_reg & !sda_reg & sda;
  wire rise = scl & !scl_reg;
  wire [6:0] own = sel_reg ? `TCI_ADDR7_ALT : `TCI_ADDR7_MAIN;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // idle level of the lines, so leaving reset shows no false edge
      scl_reg <= 1'b1;
      sda_reg <= 1'b1;
      per_reg <= 9'h1ff;
      first_reg <= 1'b0;
      rd_reg <= 1'b0;
      hit_reg <= 1'b0;
      idle_reg <= 1'b1;
      sel_reg <= 1'b0;
      cnt_reg <= 4'h0;
      sh_reg <= 8'h00;
    end else begin
      scl_reg <= scl;
      sda_reg <= sda;
      // cycles since the last scl rise, held at full scale when idle
      if (rise) per_reg <= 9'h000;
      else if (per_reg != 9'h1ff) per_reg <= per_reg + 9'h001;
      // strap is followed while the pin is low, so it holds the last level
      if (!rst_pin_n) sel_reg <= int_pin;
      if (st) begin
        cnt_reg <= 4'h0;
        first_reg <= 1'b1;
        idle_reg <= 1'b0;
      end else if (sp) begin
        idle_reg <= 1'b1;
        hit_reg <= 1'b0;
      end else if (rise) begin
        cnt_reg <= (cnt_reg == 4'h8) ? 4'h0 : cnt_reg + 4'h1;
        if (cnt_reg < 4'h8) sh_reg <= {sh_reg[6:0], sda};
        if (cnt_reg == 4'h8 && first_reg) begin
          first_reg <= 1'b0;
          rd_reg <= sh_reg[0];
          hit_reg <= sh_reg[7:1] == own;
        end
      end
    end
  end
  // ------------------------------------
  // checks
  // ------------------------------------
  strap_release_a: assert property (@(posedge clk) disable iff (!rst_n)
    !rst_pin_n |-> sda_oe_n_tgt) else $error("target drove in reset");
  idle_quiet_a: assert property (@(posedge clk) disable iff (!rst_n)
    idle_reg |-> sda_oe_n_tgt) else $error("target drove idle bus");
  high_stable_a: assert property (@(posedge clk) disable iff (!rst_n)
    scl && $past(scl) |-> $stable(sda_oe_n_tgt))
    else $error("target sda moved with scl high");
  stop_release_a: assert property (@(posedge clk) disable iff (!rst_n)
    sp |=> sda_oe_n_tgt [*8]) else $error("target drove after stop");
  addr_ack_a: assert property (@(posedge clk) disable iff (!rst_n)
    rise && first_reg && cnt_reg == 4'h8 |-> sda == (sh_reg[7:1] != own))
    else $error("address ack wrong");
  write_ack_a: assert property (@(posedge clk) disable iff (!rst_n)
    rise && hit_reg && !rd_reg && !first_reg && cnt_reg == 4'h8
    |-> !sda_oe_n_tgt) else $error("write byte not acked");
  write_bits_a: assert property (@(posedge clk) disable iff (!rst_n)
    rise && !rd_reg && !first_reg && cnt_reg < 4'h8 |-> sda_oe_n_tgt)
    else $error("target drove a host bit");
  read_ack_a: assert property (@(posedge clk) disable iff (!rst_n)
    rise && rd_reg && !first_reg && cnt_reg == 4'h8 |-> sda_oe_n_tgt)
    else $error("target drove host ack slot");
  rate_limit_a: assert property (@(posedge clk) disable iff (!rst_n)
    rise |-> per_reg >= 9'(`TCI_CYC_UP(`TCI_TBIT_NS) - 1))
    else $error("scl faster than bit rate limit");
endmodule // tci_monitor

// ### tb/touch_ctrl_i2c_slave_tb_top.sv
// self-checking bench: host and target ends joined over the link
`timescale 1ns/1ps
module touch_ctrl_i2c_slave_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sel = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_read = 1'b0;
  logic [15:0] cmd_ptr = 16'h0000;
  logic [7:0] cmd_len = 8'h00;
  logic [7:0] wdata = 8'h3c;
  logic [7:0] rd_data = 8'h00;
  logic cmd_ready, wdata_take, rdata_valid, done, nack_err;
  logic wr_en, rd_en, t_sel, busy;
  logic [15:0] wr_addr, rd_addr;
  logic [15:0] exp_wa = 16'h12fe;
  logic [7:0] wr_data, rdata;
  logic [7:0] mem [0:255];
  logic [7:0] wq [0:3] = '{8'h3c, 8'ha5, 8'h0f, 8'hc3};
  int wi = 0;
  int wn = 0;
  int ri = 0;
  int roff = 0;
  logic exp_nak = 1'b0;
  int error_cnt = 0;
  int total_checks = 0;
  tci_if link ();
  tci_host tci_host_inst (.clk, .rst_n, .bus(link.host), .addr_sel(sel),
    .cmd_valid, .cmd_ready, .cmd_read, .cmd_ptr, .cmd_len, .wdata,
    .wdata_take, .rdata, .rdata_valid, .done, .nack_err);
  tci_target tci_target_inst (.clk, .rst_n, .bus(link.tgt), .wr_en,
    .wr_addr, .wr_data, .rd_en, .rd_addr, .rd_data, .addr_sel(t_sel),
    .busy);
  tci_monitor tci_monitor_inst (.clk, .rst_n, .scl(link.scl),
    .sda(link.sda), .sda_oe_n_tgt(link.sda_oe_n_tgt),
    .rst_pin_n(link.rst_pin_n), .int_pin(link.int_pin));
  always #5 clk = ~clk;
  // ------------------------------------
  // user sides and helpers
  // ------------------------------------
  function automatic bit ck(input bit f);
    total_checks++;
    return f;
  endfunction
  task automatic bad(input string m);
    error_cnt++;
    $display("BAD %0t %s", $time, m);
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // memory behind the target; one-cycle fetch latency as the port expects
  always @(posedge clk) begin
    rd_data <= mem[rd_addr[7:0]];
    if (wdata_take) begin
      wi <= wi + 1;
      wdata <= wq[(wi + 1) % 4];
    end
    if (wr_en) begin
      mem[wr_addr[7:0]] <= wr_data;
      if (ck(wr_addr !== exp_wa || wr_data !== wq[wn])) bad("write");
      exp_wa <= exp_wa + 16'h0001;
      wn <= wn + 1;
    end
    if (rdata_valid) begin
      if (ck(rdata !== wq[ri + roff])) bad("read data");
      ri <= ri + 1;
    end
  end
  task automatic power_up(input logic s);
    @(posedge clk);
    rst_n <= 1'b0;
    sel <= s;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  task automatic run(input bit rd, input logic [15:0] p, input logic [7:0] n);
    int k;
    k = 0;
    while (cmd_ready !== 1'b1 && k < 5000) begin
      @(negedge clk);
      k++;
    end
    if (ck(k >= 5000)) bad("never ready");
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_read <= rd;
    cmd_ptr <= p;
    cmd_len <= n;
    @(posedge clk);
    cmd_valid <= 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 30000) begin
      @(negedge clk);
      k++;
    end
    if (ck(k >= 30000 || nack_err !== exp_nak)) bad("no clean done");
  endtask
  // ------------------------------------
  // scenarios
  // ------------------------------------
  task automatic t_write();
    run(1'b0, 16'h12fe, 8'h03);
    if (ck(wn != 3)) bad("write count");
    if (ck(busy !== 1'b0)) bad("busy after stop");
  endtask
  task automatic t_read();
    run(1'b1, 16'h12fe, 8'h03);
    if (ck(ri != 3)) bad("read count");
    if (ck(link.sda_oe_n_tgt !== 1'b1)) bad("sda held");
  endtask
  task automatic t_strap();
    power_up(1'b1);
    ri = 0;
    roff = 1;
    run(1'b1, 16'h12ff, 8'h01);
    if (ck(t_sel !== 1'b1)) bad("strap");
    if (ck(ri != 1)) bad("single read");
  endtask
  task automatic t_nomatch();
    power_up(1'b0);
    // host moves to the other pair once the target has latched its strap
    wait (link.rst_pin_n === 1'b1);
    repeat (8) @(posedge clk);
    sel <= 1'b1;
    exp_nak = 1'b1;
    run(1'b0, 16'h0040, 8'h01);
    if (ck(wn != 3)) bad("write on miss");
    if (ck(busy !== 1'b0)) bad("busy on miss");
    if (ck(t_sel !== 1'b0)) bad("strap on miss");
  endtask
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    power_up(1'b0);
    t_write();
    t_read();
    t_strap();
    t_nomatch();
    summarize();
  end
  // whole run is near 55k cycles; cut off well before it could hang forever
  initial begin
    #800000;
    bad("watchdog");
    summarize();
  end
endmodule // touch_ctrl_i2c_slave_tb_top
